/* File: inc/rsf_defs.vh */
`ifndef RSF_DEFS_VH
`define RSF_DEFS_VH

// =====================================================
// Register offsets
`define RSF_OFS_SPREAD_MODE 8'h6b
`define RSF_OFS_SPREAD_RANGE 8'h6c
`define RSF_OFS_RAMP_FREQ 8'h6d
`define RSF_OFS_TRI_STEP 8'h6e
`define RSF_OFS_AMP_BOUND 8'h6f
`define RSF_OFS_CHANNEL_FAULT_STATUS 8'h70
`define RSF_OFS_GLOB_FAULT_A 8'h71
`define RSF_OFS_GLOB_FAULT_B 8'h72

// =====================================================
// Reset values
`define RSF_RST_SPREAD_MODE 8'h00
`define RSF_RST_SPREAD_RANGE 8'h00
`define RSF_RST_RAMP_FREQ 8'h50
`define RSF_RST_TRI_STEP 8'h11
`define RSF_RST_AMP_BOUND 8'h24

// =====================================================
// Field positions
`define RSF_MODE_PREDIV_BIT 5
`define RSF_MODE_MANUAL_BIT 4
`define RSF_RANDOM_MSB 6
`define RSF_RANDOM_LSB 4
`define RSF_TRIANGLE_MSB 3
`define RSF_TRIANGLE_LSB 0
`define RSF_FALL_MSB 7
`define RSF_FALL_LSB 4
`define RSF_RISE_MSB 3
`define RSF_RISE_LSB 0
`define RSF_AMP_MSB 6
`define RSF_AMP_LSB 5
`define RSF_LIMIT_MSB 4
`define RSF_LIMIT_LSB 0
`define RSF_LEFT_DC_BIT 3
`define RSF_RIGHT_DC_BIT 2
`define RSF_LEFT_OC_BIT 1
`define RSF_RIGHT_OC_BIT 0
`define RSF_OTP_CRC_BIT 7
`define RSF_BQ_WR_BIT 6
`define RSF_CLK_FAULT_BIT 2
`define RSF_PS_OV_BIT 1
`define RSF_PS_UV_BIT 0

// =====================================================
// Widths and counts
`define RSF_FAULT_COUNT 9
`define RSF_LFSR_SEED 8'h5a
`define RSF_RAMP_BASE_HZ 61440000

`endif

/* File: design/rsf_sync.v */
`timescale 1ns/1ps
`default_nettype none

module rsf_sync #(
    parameter WIDTH = 1
) (
    input wire clk_in,
    input wire rst_in,
    input wire [WIDTH-1:0] async_in,
    output wire [WIDTH-1:0] sync_out
);

    // =====================================================
    // Two-stage synchroniser per bit
    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
            reg meta_r;
            reg stable_r;
            always @(posedge clk_in or posedge rst_in) begin
                if (rst_in) begin
                    meta_r <= 1'b0;
                    stable_r <= 1'b0;
                end else begin
                    meta_r <= async_in[i];
                    stable_r <= meta_r;
                end
            end
            assign sync_out[i] = stable_r;
        end
    endgenerate

endmodule

`default_nettype wire

/* File: design/rsf_ramp_tick.v */
`timescale 1ns/1ps
`default_nettype none

module rsf_ramp_tick (
    input wire clk_in,
    input wire rst_in,
    input wire run_in,
    input wire half_rate_in,
    input wire [7:0] divisor_in,
    output reg tick_out
);

    // =====================================================
    // Prescaler: halves the source rate when requested
    reg pre_r;
    reg [7:0] cnt_r;
    reg [7:0] cnt_nxt;
    wire src_en;
    wire [7:0] last;

    assign src_en = half_rate_in ? pre_r : 1'b1;
    // Divisor zero treated as one, avoids a dead counter
    assign last = (divisor_in == 8'h00) ? 8'h00 : divisor_in - 8'h01;

    always @* begin
        cnt_nxt = cnt_r;
        if (src_en) begin
            if (cnt_r >= last)
                cnt_nxt = 8'h00;
            else
                cnt_nxt = cnt_r + 8'h01;
        end
    end

    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            pre_r <= 1'b0;
            cnt_r <= 8'h00;
            tick_out <= 1'b0;
        end else if (!run_in) begin
            pre_r <= 1'b0;
            cnt_r <= 8'h00;
            tick_out <= 1'b0;
        end else begin
            pre_r <= ~pre_r;
            cnt_r <= cnt_nxt;
            tick_out <= src_en && (cnt_r >= last);
        end
    end

endmodule

`default_nettype wire

/* File: design/rsf_regs_top.v */
// Summary of operation
// - Random spread range field, bits 6-4
// - Triangle frequency/range field, bits 3-0
// - Manual ramp frequency divisor N, reset 0x50
// - Manual triangle fall step, bits 7-4
// - Manual triangle rise step, bits 3-0
// - Manual ramp amplitude, bits 6-5
// - Manual triangle period limit, bits 4-0
// - Left DC fault flag at bit 3
// - Right DC fault flag at bit 2
// - Left over-current flag at bit 1
// - Right over-current bit 0, upper reserved zero
// - Fuse CRC error flag at bit 7
// - Biquad write error flag at bit 6
// - Manual mode bit gates manual fields
// - Manual mode half-rate PLL source select
`timescale 1ns/1ps
`default_nettype none
`include "rsf_defs.vh"

module rsf_regs_top (
    input wire CORE_CLK_IN,
    input wire RST_IN,
    input wire [7:0] REG_ADDR_IN,
    input wire [7:0] REG_WDATA_IN,
    input wire REG_WR_IN,
    input wire REG_RD_IN,
    output reg [7:0] REG_RDATA_OUT,
    output reg REG_RVALID_OUT,
    input wire LEFT_DC_FAULT_IN,
    input wire RIGHT_DC_FAULT_IN,
    input wire LEFT_OVERCURRENT_FAULT_IN,
    input wire RIGHT_OVERCURRENT_FAULT_IN,
    input wire FUSE_CRC_ERROR_IN,
    input wire BIQUAD_WRITE_ERROR_IN,
    input wire CLOCK_FAULT_IN,
    input wire POWER_STAGE_OVERVOLTAGE_IN,
    input wire POWER_STAGE_UNDERVOLTAGE_IN,
    output reg MANUAL_MODE_OUT,
    output reg HALF_RATE_SRC_OUT,
    output reg [2:0] RANDOM_SPREAD_RANGE_OUT,
    output reg [3:0] TRIANGLE_SPREAD_CTRL_OUT,
    output reg [2:0] RANDOM_DITHER_OUT,
    output reg [7:0] MANUAL_RAMP_DIVISOR_OUT,
    output reg [1:0] MANUAL_RAMP_AMPLITUDE_OUT,
    output reg [4:0] TRIANGLE_LEVEL_OUT,
    output reg TRIANGLE_FALLING_OUT,
    output reg RAMP_TICK_OUT
);

    // =====================================================
    // State codes for the triangle walker
    localparam ST_IDLE = 2'b00;
    localparam ST_RISE = 2'b01;
    localparam ST_FALL = 2'b10;

    // =====================================================
    // Register storage
    // Reserved bits are plain storage so they read back as written
    reg [7:0] spread_mode_r;
    reg [7:0] spread_range_ctrl_r;
    reg [7:0] manual_ramp_freq_r;
    reg [7:0] triangle_step_ctrl_r;
    reg [7:0] ramp_amp_boundary_r;
    reg [1:0] tri_state_r;
    reg [1:0] tri_state_nxt;
    reg [4:0] tri_level_r;
    reg [4:0] tri_level_nxt;
    reg [7:0] lfsr_r;
    reg [7:0] rdata_nxt;

    wire [`RSF_FAULT_COUNT-1:0] fault_raw;
    wire [`RSF_FAULT_COUNT-1:0] fault_sync;
    wire [7:0] channel_fault_status;
    wire [7:0] global_fault_status_a;
    wire [7:0] global_fault_status_b;
    wire manual_mode;
    wire half_rate_sel;
    wire [2:0] random_spread_range;
    wire [3:0] triangle_spread_ctrl;
    wire [7:0] manual_ramp_divisor;
    wire [3:0] triangle_fall_step;
    wire [3:0] triangle_rise_step;
    wire [1:0] manual_ramp_amplitude;
    wire [4:0] triangle_period_limit;
    wire [5:0] rise_sum;
    wire ramp_tick;
    wire wr_mode;
    wire wr_range;
    wire wr_freq;
    wire wr_step;
    wire wr_bound;

    // =====================================================
    // Fault inputs come from analog monitors, so resync first
    assign fault_raw = {FUSE_CRC_ERROR_IN, BIQUAD_WRITE_ERROR_IN, CLOCK_FAULT_IN,
                        POWER_STAGE_OVERVOLTAGE_IN, POWER_STAGE_UNDERVOLTAGE_IN,
                        LEFT_DC_FAULT_IN, RIGHT_DC_FAULT_IN,
                        LEFT_OVERCURRENT_FAULT_IN, RIGHT_OVERCURRENT_FAULT_IN};

    rsf_sync #(
        .WIDTH(`RSF_FAULT_COUNT)
    ) u_fault_sync (
        .clk_in(CORE_CLK_IN),
        .rst_in(RST_IN),
        .async_in(fault_raw),
        .sync_out(fault_sync)
    );

    // =====================================================
    // Fault status views, reserved bits held at zero
    assign channel_fault_status = {4'h0, fault_sync[3], fault_sync[2],
                                   fault_sync[1], fault_sync[0]};
    assign global_fault_status_a = {fault_sync[8], fault_sync[7], 3'b000,
                                    fault_sync[6], fault_sync[5], fault_sync[4]};
    // Over-temperature reporting lives elsewhere; reads zero here
    assign global_fault_status_b = 8'h00;

    // =====================================================
    // Write decode
    // Fault offsets have no strobe here, so writes to them fall away
    assign wr_mode = REG_WR_IN && (REG_ADDR_IN == `RSF_OFS_SPREAD_MODE);
    assign wr_range = REG_WR_IN && (REG_ADDR_IN == `RSF_OFS_SPREAD_RANGE);
    assign wr_freq = REG_WR_IN && (REG_ADDR_IN == `RSF_OFS_RAMP_FREQ);
    assign wr_step = REG_WR_IN && (REG_ADDR_IN == `RSF_OFS_TRI_STEP);
    assign wr_bound = REG_WR_IN && (REG_ADDR_IN == `RSF_OFS_AMP_BOUND);

    always @(posedge CORE_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            spread_mode_r <= `RSF_RST_SPREAD_MODE;
        end else if (wr_mode) begin
            spread_mode_r <= REG_WDATA_IN;
        end
    end

    always @(posedge CORE_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            spread_range_ctrl_r <= `RSF_RST_SPREAD_RANGE;
        end else if (wr_range) begin
            spread_range_ctrl_r <= REG_WDATA_IN;
        end
    end

    always @(posedge CORE_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            manual_ramp_freq_r <= `RSF_RST_RAMP_FREQ;
        end else if (wr_freq) begin
            manual_ramp_freq_r <= REG_WDATA_IN;
        end
    end

    always @(posedge CORE_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            triangle_step_ctrl_r <= `RSF_RST_TRI_STEP;
        end else if (wr_step) begin
            triangle_step_ctrl_r <= REG_WDATA_IN;
        end
    end

    always @(posedge CORE_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            ramp_amp_boundary_r <= `RSF_RST_AMP_BOUND;
        end else if (wr_bound) begin
            ramp_amp_boundary_r <= REG_WDATA_IN;
        end
    end

    // =====================================================
    // Field extraction
    assign manual_mode = spread_mode_r[`RSF_MODE_MANUAL_BIT];
    assign half_rate_sel = spread_mode_r[`RSF_MODE_PREDIV_BIT];
    assign random_spread_range = spread_range_ctrl_r[`RSF_RANDOM_MSB:`RSF_RANDOM_LSB];
    assign triangle_spread_ctrl = spread_range_ctrl_r[`RSF_TRIANGLE_MSB:`RSF_TRIANGLE_LSB];
    assign manual_ramp_divisor = manual_ramp_freq_r;
    assign triangle_fall_step = triangle_step_ctrl_r[`RSF_FALL_MSB:`RSF_FALL_LSB];
    assign triangle_rise_step = triangle_step_ctrl_r[`RSF_RISE_MSB:`RSF_RISE_LSB];
    assign manual_ramp_amplitude = ramp_amp_boundary_r[`RSF_AMP_MSB:`RSF_AMP_LSB];
    assign triangle_period_limit = ramp_amp_boundary_r[`RSF_LIMIT_MSB:`RSF_LIMIT_LSB];

    // =====================================================
    // Read path: one cycle latency, no side effects on any read
    // A read and a write to one offset in one cycle return the old value
    always @* begin
        case (REG_ADDR_IN)
            `RSF_OFS_SPREAD_MODE: begin
                rdata_nxt = spread_mode_r;
            end
            `RSF_OFS_SPREAD_RANGE: begin
                rdata_nxt = spread_range_ctrl_r;
            end
            `RSF_OFS_RAMP_FREQ: begin
                rdata_nxt = manual_ramp_freq_r;
            end
            `RSF_OFS_TRI_STEP: begin
                rdata_nxt = triangle_step_ctrl_r;
            end
            `RSF_OFS_AMP_BOUND: begin
                rdata_nxt = ramp_amp_boundary_r;
            end
            `RSF_OFS_CHANNEL_FAULT_STATUS: begin
                rdata_nxt = channel_fault_status;
            end
            `RSF_OFS_GLOB_FAULT_A: begin
                rdata_nxt = global_fault_status_a;
            end
            `RSF_OFS_GLOB_FAULT_B: begin
                rdata_nxt = global_fault_status_b;
            end
            default: begin
                rdata_nxt = 8'h00;
            end
        endcase
    end

    always @(posedge CORE_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            REG_RDATA_OUT <= 8'h00;
            REG_RVALID_OUT <= 1'b0;
        end else begin
            REG_RVALID_OUT <= REG_RD_IN;
            if (REG_RD_IN) begin
                REG_RDATA_OUT <= rdata_nxt;
            end
        end
    end

    // =====================================================
    // Ramp tick, only runs in manual mode
    // Lowering the divisor below the running count wraps at the next step
    rsf_ramp_tick u_ramp_tick (
        .clk_in(CORE_CLK_IN),
        .rst_in(RST_IN),
        .run_in(manual_mode),
        .half_rate_in(half_rate_sel),
        .divisor_in(manual_ramp_divisor),
        .tick_out(ramp_tick)
    );

    // =====================================================
    // Triangle walker: climbs by rise step to the limit, falls by fall step to zero
    // A zero limit parks the level at zero while the phases still alternate
    assign rise_sum = {1'b0, tri_level_r} + {2'b00, triangle_rise_step};

    always @* begin
        tri_state_nxt = tri_state_r;
        tri_level_nxt = tri_level_r;
        case (tri_state_r)
            ST_IDLE: begin
                tri_level_nxt = 5'h00;
                if (manual_mode) begin
                    tri_state_nxt = ST_RISE;
                end
            end
            ST_RISE: begin
                if (!manual_mode) begin
                    tri_state_nxt = ST_IDLE;
                    tri_level_nxt = 5'h00;
                end else if (ramp_tick) begin
                    // Clamp so a large step never overshoots the limit
                    if (rise_sum >= {1'b0, triangle_period_limit}) begin
                        tri_level_nxt = triangle_period_limit;
                        tri_state_nxt = ST_FALL;
                    end else begin
                        tri_level_nxt = rise_sum[4:0];
                    end
                end
            end
            ST_FALL: begin
                if (!manual_mode) begin
                    tri_state_nxt = ST_IDLE;
                    tri_level_nxt = 5'h00;
                end else if (ramp_tick) begin
                    if (tri_level_r <= {1'b0, triangle_fall_step}) begin
                        tri_level_nxt = 5'h00;
                        tri_state_nxt = ST_RISE;
                    end else begin
                        tri_level_nxt = tri_level_r - {1'b0, triangle_fall_step};
                    end
                end
            end
            default: begin
                tri_state_nxt = ST_IDLE;
                tri_level_nxt = 5'h00;
            end
        endcase
    end

    always @(posedge CORE_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            tri_state_r <= ST_IDLE;
            tri_level_r <= 5'h00;
        end else begin
            tri_state_r <= tri_state_nxt;
            tri_level_r <= tri_level_nxt;
        end
    end

    // =====================================================
    // Random dither source, limited to the programmed range width
    // Steps once per tick only, so the dither holds for a whole ramp period
    always @(posedge CORE_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            lfsr_r <= `RSF_LFSR_SEED;
        end else if (ramp_tick) begin
            lfsr_r <= {lfsr_r[6:0], lfsr_r[7] ^ lfsr_r[5] ^ lfsr_r[4] ^ lfsr_r[3]};
        end
    end

    // =====================================================
    // Registered outputs; manual fields only reach out in manual mode
    // The extra flop costs a cycle of lag but keeps the pins glitch free
    always @(posedge CORE_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            MANUAL_MODE_OUT <= 1'b0;
            HALF_RATE_SRC_OUT <= 1'b0;
            RANDOM_SPREAD_RANGE_OUT <= 3'h0;
            TRIANGLE_SPREAD_CTRL_OUT <= 4'h0;
            RANDOM_DITHER_OUT <= 3'h0;
            MANUAL_RAMP_DIVISOR_OUT <= 8'h00;
            MANUAL_RAMP_AMPLITUDE_OUT <= 2'h0;
            TRIANGLE_LEVEL_OUT <= 5'h00;
            TRIANGLE_FALLING_OUT <= 1'b0;
            RAMP_TICK_OUT <= 1'b0;
        end else begin
            MANUAL_MODE_OUT <= manual_mode;
            HALF_RATE_SRC_OUT <= manual_mode && half_rate_sel;
            RANDOM_SPREAD_RANGE_OUT <= random_spread_range;
            TRIANGLE_SPREAD_CTRL_OUT <= triangle_spread_ctrl;
            RANDOM_DITHER_OUT <= lfsr_r[2:0] & random_spread_range;
            MANUAL_RAMP_DIVISOR_OUT <= manual_mode ? manual_ramp_divisor : 8'h00;
            MANUAL_RAMP_AMPLITUDE_OUT <= manual_mode ? manual_ramp_amplitude : 2'h0;
            TRIANGLE_LEVEL_OUT <= tri_level_r;
            TRIANGLE_FALLING_OUT <= (tri_state_r == ST_FALL);
            RAMP_TICK_OUT <= ramp_tick;
        end
    end

endmodule

`default_nettype wire

/* File: verif/rsf_regs_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========
// Register port checker
module rsf_regs_asserts (
    input wire CORE_CLK_IN,
    input wire RST_IN,
    input wire [7:0] REG_ADDR_IN,
    input wire [7:0] REG_WDATA_IN,
    input wire REG_WR_IN,
    input wire REG_RD_IN,
    input wire [7:0] REG_RDATA_OUT,
    input wire REG_RVALID_OUT,
    input wire LEFT_DC_FAULT_IN,
    input wire RIGHT_DC_FAULT_IN,
    input wire LEFT_OVERCURRENT_FAULT_IN,
    input wire RIGHT_OVERCURRENT_FAULT_IN,
    input wire FUSE_CRC_ERROR_IN,
    input wire BIQUAD_WRITE_ERROR_IN,
    input wire CLOCK_FAULT_IN,
    input wire POWER_STAGE_OVERVOLTAGE_IN,
    input wire POWER_STAGE_UNDERVOLTAGE_IN,
    input wire MANUAL_MODE_OUT,
    input wire HALF_RATE_SRC_OUT,
    input wire [2:0] RANDOM_SPREAD_RANGE_OUT,
    input wire [3:0] TRIANGLE_SPREAD_CTRL_OUT,
    input wire [7:0] MANUAL_RAMP_DIVISOR_OUT,
    input wire [1:0] MANUAL_RAMP_AMPLITUDE_OUT,
    input wire [4:0] TRIANGLE_LEVEL_OUT,
    input wire RAMP_TICK_OUT
);
    reg [1:0] up_r;
    wire [7:0] chan_w = {4'h0, LEFT_DC_FAULT_IN, RIGHT_DC_FAULT_IN, LEFT_OVERCURRENT_FAULT_IN,
        RIGHT_OVERCURRENT_FAULT_IN};
    wire [7:0] glob_w = {FUSE_CRC_ERROR_IN, BIQUAD_WRITE_ERROR_IN, 3'b000, CLOCK_FAULT_IN,
        POWER_STAGE_OVERVOLTAGE_IN, POWER_STAGE_UNDERVOLTAGE_IN};
    // Flags untrusted until the synchroniser has refilled after reset
    always @(posedge CORE_CLK_IN or posedge RST_IN) begin
        if (RST_IN)
            up_r <= 2'h0;
        else if (up_r != 2'h3)
            up_r <= up_r + 2'h1;
    end
    default clocking @(posedge CORE_CLK_IN); endclocking
    default disable iff (RST_IN);
    sequence s_chan_rd;
        $stable(chan_w)[*2] ##0 (up_r == 2'h3 && REG_RD_IN && REG_ADDR_IN == 8'h70);
    endsequence
    sequence s_glob_rd;
        $stable(glob_w)[*2] ##0 (up_r == 2'h3 && REG_RD_IN && REG_ADDR_IN == 8'h71);
    endsequence
    a_chan_flags_read: assert property (s_chan_rd |=> REG_RDATA_OUT == $past(chan_w))
        else $error("channel fault read mismatch");
    a_glob_flags_read: assert property (s_glob_rd |=> REG_RDATA_OUT == $past(glob_w))
        else $error("global fault read mismatch");
    a_zero_read: assert property (REG_RD_IN && (REG_ADDR_IN >= 8'h72 || REG_ADDR_IN < 8'h6b)
        |=> REG_RDATA_OUT == 8'h00) else $error("empty location read not zero");
    a_rvalid_after_rd: assert property (REG_RD_IN |=> REG_RVALID_OUT)
        else $error("read answer missing");
    a_rvalid_has_cause: assert property (REG_RVALID_OUT |-> $past(REG_RD_IN))
        else $error("read answer without request");
    a_rdata_holds: assert property (!REG_RD_IN |=> $stable(REG_RDATA_OUT))
        else $error("read data moved without read");
    a_range_write: assert property (REG_WR_IN && REG_ADDR_IN == 8'h6c |-> ##2
        {1'b0, RANDOM_SPREAD_RANGE_OUT, TRIANGLE_SPREAD_CTRL_OUT} == ($past(REG_WDATA_IN, 2) & 8'h7f))
        else $error("spread fields not written");
    a_mode_write: assert property (REG_WR_IN && REG_ADDR_IN == 8'h6b |-> ##2
        MANUAL_MODE_OUT == |($past(REG_WDATA_IN, 2) & 8'h10)) else $error("manual mode not written");
    a_half_rate_gate: assert property (!MANUAL_MODE_OUT[*2] |-> !HALF_RATE_SRC_OUT)
        else $error("half rate outside manual mode");
    a_idle_outputs: assert property (!MANUAL_MODE_OUT[*3] |-> MANUAL_RAMP_DIVISOR_OUT == 8'h00 &&
        MANUAL_RAMP_AMPLITUDE_OUT == 2'b00 && TRIANGLE_LEVEL_OUT == 5'h00 && !RAMP_TICK_OUT)
        else $error("manual outputs active outside manual mode");
    a_tick_single: assert property (RAMP_TICK_OUT && MANUAL_RAMP_DIVISOR_OUT > 8'h01 |=> !RAMP_TICK_OUT)
        else $error("ramp tick longer than one cycle");
endmodule
`default_nettype wire

/* File: verif/rsf_regs_top_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) chk(8'(g), 8'(e))
// ==========
// Register bank bench
module rsf_regs_top_tb;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [8:0] flt = 9'h000;
    logic [7:0] rst_tab [8] = '{8'h00, 8'h00, 8'h50, 8'h11, 8'h24, 8'h00, 8'h00, 8'h00};
    wire [7:0] rdata, div;
    wire rvalid, mode, half, tick, fall;
    wire [2:0] rng, dith;
    wire [3:0] tri_c;
    wire [1:0] amp;
    wire [4:0] lvl;
    int fail_count = 0;
    int check_count = 0;
    int prev, exp, top;
    rsf_regs_top DUT (.CORE_CLK_IN(clk), .RST_IN(rst), .REG_ADDR_IN(addr), .REG_WDATA_IN(wdata),
        .REG_WR_IN(wr), .REG_RD_IN(rd), .REG_RDATA_OUT(rdata), .REG_RVALID_OUT(rvalid),
        .RIGHT_OVERCURRENT_FAULT_IN(flt[0]), .LEFT_OVERCURRENT_FAULT_IN(flt[1]),
        .RIGHT_DC_FAULT_IN(flt[2]), .LEFT_DC_FAULT_IN(flt[3]), .POWER_STAGE_UNDERVOLTAGE_IN(flt[4]),
        .POWER_STAGE_OVERVOLTAGE_IN(flt[5]), .CLOCK_FAULT_IN(flt[6]), .BIQUAD_WRITE_ERROR_IN(flt[7]),
        .FUSE_CRC_ERROR_IN(flt[8]), .MANUAL_MODE_OUT(mode), .HALF_RATE_SRC_OUT(half),
        .RANDOM_SPREAD_RANGE_OUT(rng), .TRIANGLE_SPREAD_CTRL_OUT(tri_c), .RANDOM_DITHER_OUT(dith),
        .MANUAL_RAMP_DIVISOR_OUT(div), .MANUAL_RAMP_AMPLITUDE_OUT(amp), .TRIANGLE_LEVEL_OUT(lvl),
        .TRIANGLE_FALLING_OUT(fall), .RAMP_TICK_OUT(tick));
    initial begin
        forever #12.5 clk = ~clk;
    end
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        check_count++;
        if (g !== e) begin
            fail_count++;
            $display("unexpected at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        int n;
        logic [7:0] d;
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        n = 0;
        d = 8'hxx;
        do begin
            @(posedge clk);
            n++;
        end while (rvalid !== 1'b1 && n < 4);
        if (rvalid === 1'b1)
            d = rdata;
        `CHK(d, e);
    endtask
    // Cycles between two ticks, bounded so a dead ramp cannot hang
    task automatic tick_gap(input int e);
        int n;
        n = 0;
        while (tick !== 1'b1 && n < 600) begin
            @(posedge clk);
            n++;
        end
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (tick !== 1'b1 && n < 600);
        `CHK(n, e);
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        #(25 * 20000);
        fail_count++;
        complete_run;
    end
    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 8; i++)
            rd_chk(8'(8'h6b + i), rst_tab[i]);
        `CHK({mode, half, amp, div[3:0]}, 8'h00);
        wr_reg(8'h6b, 8'h10);
        repeat (2) @(posedge clk);
        `CHK({mode, half, amp, 4'h0}, 8'h90);
        `CHK(div, 8'h50);
        tick_gap(80);
        wr_reg(8'h6b, 8'h00);
        // Every bit of offsets 0x6c to 0x6f, reserved ones included, must store both levels
        foreach (rst_tab[j]) begin
            for (int i = 0; i < 4; i++)
                wr_reg(8'(8'h6c + i), (j == 0) ? 8'hff : 8'h00);
            if (j == 0)
                `CHK({1'b0, rng, tri_c}, 8'h7f);
            for (int i = 0; i < 4; i++)
                rd_chk(8'(8'h6c + i), (j == 0) ? 8'hff : 8'h00);
            if (j == 1)
                break;
        end
        foreach (rst_tab[i]) begin
            wr_reg(8'h70 + 8'(i % 4), 8'hff);
            rd_chk(8'h70 + 8'(i % 4), 8'h00);
        end
        wr_reg(8'h80, 8'h5a);
        rd_chk(8'h80, 8'h00);
        for (int i = 0; i <= 10; i++) begin
            flt <= (i == 9) ? 9'h1ff : ((i == 10) ? 9'h000 : 9'h001 << i);
            repeat (3) @(posedge clk);
            rd_chk(8'h70, {4'h0, flt[3:0]});
            rd_chk(8'h71, {flt[8:7], 3'b000, flt[6:4]});
            rd_chk(8'h70, {4'h0, flt[3:0]});
        end
        wr_reg(8'h6d, 8'h04);
        wr_reg(8'h6e, 8'h23);
        wr_reg(8'h6f, 8'h47);
        wr_reg(8'h6b, 8'h10);
        repeat (2) @(posedge clk);
        `CHK({amp, 2'b00, div[3:0]}, 8'h84);
        tick_gap(4);
        // Walker already runs during the tick check, so start from the shown level
        prev = lvl;
        top = 0;
        repeat (200) begin
            @(posedge clk);
            if (lvl != 5'(prev)) begin
                exp = (lvl > prev) ? ((prev + 3 > 7) ? 7 : prev + 3) : ((prev < 2) ? 0 : prev - 2);
                `CHK(lvl, exp);
                `CHK(fall, exp != 0 && (lvl < prev || exp == 7));
                prev = lvl;
                top = (prev > top) ? prev : top;
            end
        end
        `CHK(top, 7);
        `CHK(dith, 8'h00);
        wr_reg(8'h6b, 8'h30);
        repeat (2) @(posedge clk);
        `CHK({mode, half}, 8'h03);
        tick_gap(8);
        wr_reg(8'h6b, 8'h20);
        repeat (4) @(posedge clk);
        `CHK({mode, half, amp, lvl[3:0]}, 8'h00);
        `CHK(div, 8'h00);
        complete_run;
    end
endmodule
bind rsf_regs_top rsf_regs_asserts u_chk (.CORE_CLK_IN, .RST_IN, .REG_ADDR_IN, .REG_WDATA_IN,
    .REG_WR_IN, .REG_RD_IN, .REG_RDATA_OUT, .REG_RVALID_OUT, .LEFT_DC_FAULT_IN, .RIGHT_DC_FAULT_IN,
    .LEFT_OVERCURRENT_FAULT_IN, .RIGHT_OVERCURRENT_FAULT_IN, .FUSE_CRC_ERROR_IN, .BIQUAD_WRITE_ERROR_IN,
    .CLOCK_FAULT_IN, .POWER_STAGE_OVERVOLTAGE_IN, .POWER_STAGE_UNDERVOLTAGE_IN, .MANUAL_MODE_OUT,
    .HALF_RATE_SRC_OUT, .RANDOM_SPREAD_RANGE_OUT, .TRIANGLE_SPREAD_CTRL_OUT, .MANUAL_RAMP_DIVISOR_OUT,
    .MANUAL_RAMP_AMPLITUDE_OUT, .TRIANGLE_LEVEL_OUT, .RAMP_TICK_OUT);
`default_nettype wire
